// >>> sfr_dev.sv
/*
 flash end of the read path: read-byte fifo and the command sequencer.
 assumes a memory on the user side answering each req_valid pulse in order
 by pushing one byte through mem_valid/mem_data within a few clocks.
*/
`timescale 1ns/1ps
module sfr_fifo
   import sfr_pkg::*;
#(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         ce,
   input  wire logic         flush,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0]         cnt;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic                rdy;
   } sfr_fifo_st_t;
   sfr_fifo_st_t q;
   sfr_fifo_st_t n;
   logic         push;
   logic         pop;

   always_comb begin
      n = q;
      push = in_valid & q.rdy;
      pop = out_ready & (q.cnt != '0);
      if (push) begin
         n.mem[q.wp] = in_data;
         n.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
      end
      if (pop)
         n.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
      n.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      if (flush) begin
         n.cnt = '0;
         n.wp = '0;
         n.rp = '0;
      end
      // registered so the ready port is a flop; full is honest next cycle
      n.rdy = n.cnt < (AW + 1)'(D);
      if (srst) begin
         n = '0;
         n.rdy = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || ce)
         q <= n;
   end

   assign in_ready  = q.rdy;
   assign out_valid = q.cnt != '0;
   assign out_data  = q.mem[q.rp];
endmodule : sfr_fifo

module sfr_dev
   import sfr_pkg::*;
#(
   parameter int ADDR_W = 25,
   parameter int FIFO_D = 8
) (
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              ce,
   sfr_link_if.dev                lnk,
   input  wire sfr_proto_t        proto,
   input  wire logic              dtr_en,
   input  wire logic              nv_addr4,
   input  wire logic              addr4_enter,
   input  wire logic              addr4_exit,
   input  wire logic [4:0]        dummy_cfg,
   output logic                   req_valid,
   output logic [ADDR_W-1:0]      req_addr,
   input  wire logic              mem_valid,
   input  wire logic [7:0]        mem_data,
   output logic                   mem_ready,
   output logic                   busy
);
   localparam int CW = $clog2(FIFO_D) + 1;
   typedef enum logic [2:0] {
      ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE
   } sfr_dev_state_t;
   // synchroniser bits are {data[3:0], sclk, cs_n}
   typedef struct packed {
      logic [5:0]       s1;
      logic [5:0]       s2;
      logic [5:0]       s3;
      logic [5:0]       stb;
      sfr_dev_state_t   st;
      logic             a4;
      sfr_cmd_t         cmd;
      logic             ph_dtr;
      logic [5:0]       cnt;
      logic [5:0]       need;
      logic [31:0]      sr;
      logic [4:0]       dcnt;
      logic [ADDR_W-1:0] raddr;
      logic [ADDR_W-1:0] req_addr;
      logic             rq;
      logic [CW-1:0]    credit;
      logic [7:0]       ob;
      logic [3:0]       ocnt;
      logic [3:0]       dout;
      logic [3:0]       doe_n;
      logic             busy;
   } sfr_dev_st_t;

   sfr_dev_st_t q;
   sfr_dev_st_t n;
   sfr_cmd_t    c;
   logic        rise;
   logic        fall;
   logic        in_edge;
   logic        out_edge;
   logic        issue;
   logic        pop;
   logic [2:0]  ln;
   logic [3:0]  din;
   logic [31:0] shifted;
   logic [4:0]  dnum;
   logic [7:0]  b;
   logic        f_valid;
   logic [7:0]  f_data;

   always_comb begin
      n = q;
      c = q.cmd;
      pop = 1'b0;
      issue = 1'b0;
      b = q.ob;
      dnum = '0;
      n.rq = 1'b0;
      n.s1 = {lnk.serial_data_lines, lnk.sclk, lnk.cs_n};
      n.s2 = q.s1;
      n.s3 = q.s2;
      // a pin change counts once the second and third stage agree
      n.stb = (q.s3 & ~(q.s2 ^ q.s3)) | (q.stb & (q.s2 ^ q.s3));
      rise = n.stb[1] & ~q.stb[1];
      fall = ~n.stb[1] & q.stb[1];
      din = n.stb[5:2];
      in_edge = rise | (fall & q.ph_dtr);
      out_edge = q.ph_dtr ? (rise | fall) : fall;
      ln = (q.st == ST_CMD) ? sfr_lanes(proto) : q.cmd.al;
      case (ln)
         L1:      shifted = {q.sr[30:0], din[0]};
         L2:      shifted = {q.sr[29:0], din[1:0]};
         default: shifted = {q.sr[27:0], din};
      endcase
      if (addr4_enter)
         n.a4 = 1'b1;
      else if (addr4_exit)
         n.a4 = 1'b0;
      case (q.st)
         ST_IDLE: begin
            if (!n.stb[0]) begin
               n.st = ST_CMD;
               n.cnt = '0;
               n.sr = '0;
               n.ph_dtr = dtr_en;
               n.busy = 1'b1;
            end
         end
         ST_CMD: begin
            if (in_edge) begin
               n.sr = shifted;
               n.cnt = q.cnt + 6'(ln);
               if (n.cnt == CMD_BITS) begin
                  c = sfr_decode(shifted[7:0], proto, dtr_en, q.a4);
                  n.cmd = c;
                  n.ph_dtr = c.dtr;
                  n.cnt = '0;
                  n.sr = '0;
                  n.need = c.a4 ? ADDR4_BITS : ADDR3_BITS;
                  n.st = c.ok ? ST_ADDR : ST_IGNORE;
               end
            end
         end
         ST_ADDR: begin
            if (in_edge) begin
               n.sr = shifted;
               n.cnt = q.cnt + 6'(ln);
               if (n.cnt == q.need) begin
                  n.raddr = shifted[ADDR_W-1:0];
                  n.credit = '0;
                  n.ocnt = '0;
                  case (q.cmd.dk)
                     SFR_DK_NONE: dnum = '0;
                     SFR_DK_WORD: dnum = WORD_DUMMY;
                     // zero in the volatile setting means factory default
                     default: dnum = (dummy_cfg == '0) ? DUMMY_FACTORY
                                                       : dummy_cfg;
                  endcase
                  n.dcnt = dnum;
                  n.st = (dnum == '0) ? ST_DATA : ST_DUMMY;
               end
            end
         end
         ST_DUMMY: begin
            if (rise) begin
               n.dcnt = q.dcnt - 1'b1;
               if (q.dcnt == 5'h01)
                  n.st = ST_DATA;
            end
         end
         ST_DATA: begin
            if (out_edge) begin
               if (q.ocnt == '0) begin
                  pop = 1'b1;
                  // a late memory shows as a fixed filler byte, not a stall
                  b = f_valid ? f_data : UNDERRUN_BYTE;
               end
               case (q.cmd.dl)
                  L1: begin
                     n.dout = {2'b00, b[7], 1'b0};
                     n.doe_n = 4'b1101;
                  end
                  L2: begin
                     n.dout = {2'b00, b[7:6]};
                     n.doe_n = 4'b1100;
                  end
                  default: begin
                     n.dout = b[7:4];
                     n.doe_n = 4'b0000;
                  end
               endcase
               n.ob = b << q.cmd.dl;
               n.ocnt = ((q.ocnt == '0) ? BYTE_BITS : q.ocnt)
                        - {1'b0, q.cmd.dl};
            end
         end
         ST_IGNORE: n.st = ST_IGNORE;
         default:   n.st = ST_IDLE;
      endcase
      // prefetch from the address; wraps at the die boundary by width
      if ((q.st == ST_DUMMY || q.st == ST_DATA)
            && q.credit < CW'(FIFO_D)) begin
         issue = 1'b1;
         n.rq = 1'b1;
         n.req_addr = q.raddr;
         n.raddr = q.raddr + 1'b1;
      end
      if (q.st == ST_DUMMY || q.st == ST_DATA)
         n.credit = q.credit + CW'(issue) - CW'(pop);
      if (q.st != ST_IDLE && n.stb[0]) begin
         n.st = ST_IDLE;
         n.doe_n = 4'b1111;
         n.ph_dtr = 1'b0;
         n.rq = 1'b0;
         n.busy = 1'b0;
      end
      if (srst) begin
         n = '0;
         n.s1 = '1;
         n.s2 = '1;
         n.s3 = '1;
         n.stb = '1;
         n.doe_n = 4'b1111;
         n.a4 = nv_addr4;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || ce)
         q <= n;
   end

   sfr_fifo #(
      .W (8),
      .D (FIFO_D)
   ) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .ce        (ce),
      .flush     (q.st == ST_IDLE),
      .in_valid  (mem_valid),
      .in_data   (mem_data),
      .in_ready  (mem_ready),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (pop & ce)
   );

   assign lnk.d_out  = q.dout;
   assign lnk.d_oe_n = q.doe_n;
   assign req_valid  = q.rq;
   assign req_addr   = q.req_addr;
   assign busy       = q.busy;
endmodule : sfr_dev

// >>> sfr_pkg.sv
/*
 shared constants, opcode decoder and types for the serial flash read path.
 assumes both link ends and the bench import it; no clock or reset here.
*/
package sfr_pkg;
   localparam logic [7:0] OP_READ = 8'h03, OP_FAST = 8'h0b, OP_DOUT = 8'h3b;
   localparam logic [7:0] OP_DIO = 8'hbb, OP_QOUT = 8'h6b, OP_QIO = 8'heb;
   localparam logic [7:0] OP_DTR_FAST = 8'h0d, OP_DTR_DOUT = 8'h3d;
   localparam logic [7:0] OP_DTR_DIO = 8'hbd, OP_DTR_QOUT = 8'h6d;
   localparam logic [7:0] OP_DTR_QIO = 8'hed, OP_WORD = 8'he7;
   localparam logic [7:0] OP4_READ = 8'h13, OP4_FAST = 8'h0c, OP4_DOUT = 8'h3c;
   localparam logic [7:0] OP4_DIO = 8'hbc, OP4_QOUT = 8'h6c, OP4_QIO = 8'hec;
   localparam logic [7:0] OP4_DTR_FAST = 8'h0e, OP4_DTR_DIO = 8'hbe;
   localparam logic [7:0] OP4_DTR_QIO = 8'hee;
   localparam logic [5:0] CMD_BITS   = 6'h08;
   localparam logic [5:0] ADDR3_BITS = 6'h18;
   localparam logic [5:0] ADDR4_BITS = 6'h20;
   localparam logic [3:0] BYTE_BITS  = 4'h8;
   localparam logic [4:0] WORD_DUMMY = 5'h04;
   localparam logic [4:0] DUMMY_FACTORY = 5'h08;
   localparam logic [7:0] UNDERRUN_BYTE = 8'hff;
   localparam logic [2:0] L1 = 3'h1, L2 = 3'h2, L4 = 3'h4;

   typedef enum logic [1:0] {SFR_EXT, SFR_DUAL, SFR_QUAD} sfr_proto_t;
   typedef enum logic [1:0] {SFR_DK_NONE, SFR_DK_CFG, SFR_DK_WORD} sfr_dk_t;
   typedef struct packed {
      logic       ok;
      logic       dtr;
      logic       a4;
      logic [2:0] al;
      logic [2:0] dl;
      sfr_dk_t    dk;
   } sfr_cmd_t;

   function automatic logic [2:0] sfr_lanes(input sfr_proto_t p);
      case (p)
         SFR_EXT:  return L1;
         SFR_DUAL: return L2;
         default:  return L4;
      endcase
   endfunction : sfr_lanes

   function automatic sfr_cmd_t sfr_decode(input logic [7:0] op,
         input sfr_proto_t p, input logic dtr_en, input logic a4_en);
      sfr_cmd_t c;
      c = '{ok: 1'b1, dtr: dtr_en, a4: a4_en, al: L1, dl: L1, dk: SFR_DK_CFG};
      case (op)
         OP_READ, OP4_READ: c.dk = SFR_DK_NONE;
         OP_FAST, OP4_FAST, OP_DTR_FAST, OP4_DTR_FAST: c.dk = SFR_DK_CFG;
         OP_DOUT, OP4_DOUT, OP_DTR_DOUT: c.dl = L2;
         OP_DIO, OP4_DIO, OP_DTR_DIO, OP4_DTR_DIO: begin
            c.al = L2;
            c.dl = L2;
         end
         OP_QOUT, OP4_QOUT, OP_DTR_QOUT: c.dl = L4;
         OP_QIO, OP4_QIO, OP_DTR_QIO, OP4_DTR_QIO: begin
            c.al = L4;
            c.dl = L4;
         end
         OP_WORD: begin
            c.al = L4;
            c.dl = L4;
            c.dk = SFR_DK_WORD;
            c.ok = (p != SFR_DUAL) && !dtr_en;
         end
         default: c.ok = 1'b0;
      endcase
      // dedicated opcodes force their mode whatever the settings say
      if (op inside {OP_DTR_FAST, OP_DTR_DOUT, OP_DTR_DIO, OP_DTR_QOUT,
            OP_DTR_QIO, OP4_DTR_FAST, OP4_DTR_DIO, OP4_DTR_QIO})
         c.dtr = 1'b1;
      if (op inside {OP4_READ, OP4_FAST, OP4_DOUT, OP4_DIO, OP4_QOUT, OP4_QIO,
            OP4_DTR_FAST, OP4_DTR_DIO, OP4_DTR_QIO})
         c.a4 = 1'b1;
      if (p != SFR_EXT) begin
         c.al = sfr_lanes(p);
         c.dl = sfr_lanes(p);
      end
      return c;
   endfunction : sfr_decode
endpackage : sfr_pkg

// >>> sfr_link_if.sv
/*
 link between host and flash: select, serial clock, four data lines.
 assumes lines nobody drives are pulled high; contention is not modelled.
*/
`timescale 1ns/1ps
interface sfr_link_if;
   logic       cs_n;
   logic       sclk;
   logic [3:0] h_out;
   logic [3:0] h_oe_n;
   logic [3:0] d_out;
   logic [3:0] d_oe_n;
   logic [3:0] serial_data_lines;

   for (genvar i = 0; i < 4; i++) begin : g_line
      assign serial_data_lines[i] = !h_oe_n[i] ? h_out[i] :
                                    !d_oe_n[i] ? d_out[i] : 1'b1;
   end

   modport host (output cs_n, sclk, h_out, h_oe_n,
                 input  serial_data_lines);
   modport dev  (input  cs_n, sclk, serial_data_lines,
                 output d_out, d_oe_n);
endinterface : sfr_link_if

// >>> sfr_host.sv
/*
 host end: makes select and the serial clock by a divider, sends opcode,
 address and dummies, and collects a given number of read bytes.
 assumes the flash end shares the package decoder and its settings.
*/
`timescale 1ns/1ps
module sfr_host
   import sfr_pkg::*;
#(
   parameter int HALF = 16
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        ce,
   sfr_link_if.host         lnk,
   input  wire logic        start,
   input  wire logic [7:0]  opcode,
   input  wire logic [31:0] addr,
   input  wire logic [15:0] nbytes,
   input  wire sfr_proto_t  proto,
   input  wire logic        dtr_en,
   input  wire logic        addr4,
   input  wire logic [4:0]  dummy_cfg,
   output logic             busy,
   output logic             rx_valid,
   output logic [7:0]       rx_data,
   output logic             done
);
   localparam logic [15:0] DIV_END = 16'(HALF - 1);
   localparam logic [15:0] DIV_MID = 16'(HALF / 2);
   typedef enum logic [2:0] {
      HS_IDLE, HS_CMD, HS_ADDR, HS_DUMMY, HS_DATA, HS_END
   } sfr_host_state_t;
   typedef struct packed {
      logic [3:0]      s1;
      logic [3:0]      s2;
      logic [3:0]      s3;
      logic [3:0]      stb;
      sfr_host_state_t st;
      logic [15:0]     div;
      sfr_cmd_t        cmd;
      logic            ph_dtr;
      logic [31:0]     tx;
      logic [5:0]      cnt;
      logic [5:0]      need;
      logic [4:0]      dcnt;
      logic [15:0]     left;
      logic            armed;
      logic [7:0]      rb;
      logic [3:0]      rcnt;
      logic            cs_n;
      logic            sclk;
      logic [3:0]      hout;
      logic [3:0]      hoe_n;
      logic            busy;
      logic            rx_valid;
      logic [7:0]      rx_data;
      logic            done;
   } sfr_host_st_t;

   sfr_host_st_t q;
   sfr_host_st_t n;
   sfr_cmd_t     c;
   logic [2:0]   ln;
   logic         t_mid;
   logic         t_end;
   logic         rise;
   logic         cedge;

   always_comb begin
      n = q;
      c = sfr_decode(opcode, proto, dtr_en, addr4);
      n.rx_valid = 1'b0;
      n.done = 1'b0;
      n.s1 = lnk.serial_data_lines;
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.stb = (q.s3 & ~(q.s2 ^ q.s3)) | (q.stb & (q.s2 ^ q.s3));
      t_mid = (q.st != HS_IDLE) && (q.div == DIV_MID);
      t_end = (q.st != HS_IDLE) && (q.div == DIV_END);
      rise = ~q.sclk;
      cedge = t_end && (rise || q.ph_dtr);
      ln = (q.st == HS_CMD) ? sfr_lanes(proto) : q.cmd.al;
      if (q.st != HS_IDLE)
         n.div = t_end ? '0 : q.div + 1'b1;
      if (t_end && q.st != HS_END)
         n.sclk = ~q.sclk;
      // new bits settle half way between edges, away from both edges
      if ((q.st == HS_CMD || q.st == HS_ADDR) && t_mid
            && (q.ph_dtr || !q.sclk)) begin
         case (ln)
            L1: begin
               n.hout = {3'b000, q.tx[31]};
               n.hoe_n = 4'b1110;
            end
            L2: begin
               n.hout = {2'b00, q.tx[31:30]};
               n.hoe_n = 4'b1100;
            end
            default: begin
               n.hout = q.tx[31:28];
               n.hoe_n = 4'b0000;
            end
         endcase
         n.tx = q.tx << ln;
      end
      // lines are let go half a beat after the last bit: the edge that
      // takes that bit must still see it on the wire, not the pull-up
      if (t_mid && q.st != HS_CMD && q.st != HS_ADDR)
         n.hoe_n = 4'b1111;
      case (q.st)
         HS_IDLE: begin
            if (start) begin
               n.st = HS_CMD;
               n.cmd = c;
               n.cs_n = 1'b0;
               n.busy = 1'b1;
               n.div = '0;
               n.cnt = '0;
               n.tx = {opcode, 24'h000000};
               n.ph_dtr = dtr_en;
               n.left = nbytes;
            end
         end
         HS_CMD: begin
            if (cedge) begin
               n.cnt = q.cnt + 6'(ln);
               if (n.cnt == CMD_BITS) begin
                  n.cnt = '0;
                  n.ph_dtr = q.cmd.dtr;
                  n.need = q.cmd.a4 ? ADDR4_BITS : ADDR3_BITS;
                  n.tx = q.cmd.a4 ? addr : {addr[23:0], 8'h00};
                  n.st = q.cmd.ok ? HS_ADDR : HS_END;
               end
            end
         end
         HS_ADDR: begin
            if (cedge) begin
               n.cnt = q.cnt + 6'(ln);
               if (n.cnt == q.need) begin
                  n.armed = 1'b0;
                  n.rcnt = '0;
                  case (q.cmd.dk)
                     SFR_DK_NONE: n.dcnt = '0;
                     SFR_DK_WORD: n.dcnt = WORD_DUMMY;
                     default: n.dcnt = (dummy_cfg == '0) ? DUMMY_FACTORY
                                                         : dummy_cfg;
                  endcase
                  n.st = (n.dcnt == '0) ? HS_DATA : HS_DUMMY;
               end
            end
         end
         HS_DUMMY: begin
            if (t_end && rise) begin
               n.dcnt = q.dcnt - 1'b1;
               if (q.dcnt == 5'h01)
                  n.st = HS_DATA;
            end
         end
         HS_DATA: begin
            if (t_end) begin
               n.armed = q.armed | q.ph_dtr | ~rise;
               if (q.armed && (q.ph_dtr || rise)) begin
                  case (q.cmd.dl)
                     L1:      n.rb = {q.rb[6:0], q.stb[1]};
                     L2:      n.rb = {q.rb[5:0], q.stb[1:0]};
                     default: n.rb = {q.rb[3:0], q.stb};
                  endcase
                  n.rcnt = q.rcnt + {1'b0, q.cmd.dl};
                  if (n.rcnt == BYTE_BITS) begin
                     n.rcnt = '0;
                     n.rx_valid = 1'b1;
                     n.rx_data = n.rb;
                     n.left = q.left - 1'b1;
                     if (q.left <= 16'h0001)
                        n.st = HS_END;
                  end
               end
            end
         end
         HS_END: begin
            if (t_end) begin
               if (q.sclk) begin
                  n.sclk = 1'b0;
               end else begin
                  n.cs_n = 1'b1;
                  n.st = HS_IDLE;
                  n.busy = 1'b0;
                  n.done = 1'b1;
                  n.ph_dtr = 1'b0;
               end
            end
         end
         default: n.st = HS_IDLE;
      endcase
      if (srst) begin
         n = '0;
         n.s1 = '1;
         n.s2 = '1;
         n.s3 = '1;
         n.stb = '1;
         n.cs_n = 1'b1;
         n.hoe_n = 4'b1111;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || ce)
         q <= n;
   end

   assign lnk.cs_n   = q.cs_n;
   assign lnk.sclk   = q.sclk;
   assign lnk.h_out  = q.hout;
   assign lnk.h_oe_n = q.hoe_n;
   assign busy       = q.busy;
   assign rx_valid   = q.rx_valid;
   assign rx_data    = q.rx_data;
   assign done       = q.done;
endmodule : sfr_host

// >>> sfr_chk.sv
/*
 link checker: relations between select, clock and line enables.
 assumes a mode-0 clock with half periods of at least 9 clocks.
*/
`timescale 1ns/1ps
module sfr_chk (
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       cs_n,
   input wire logic       sclk,
   input wire logic [3:0] h_oe_n,
   input wire logic [3:0] d_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   chk_no_contention: assert property ((h_oe_n | d_oe_n) == 4'hf)
      else $error("both ends drive a line");
   chk_dev_silent: assert property (
      $fell(cs_n) |-> (d_oe_n == 4'hf) [*8])
      else $error("flash drives during opcode");
   chk_release_lines: assert property (
      $rose(cs_n) |-> ##[1:8] d_oe_n == 4'hf)
      else $error("flash holds lines after deselect");
   chk_out_in_frame: assert property ($fell(d_oe_n[1]) |-> !cs_n)
      else $error("flash drives while deselected");
   chk_sclk_idle: assert property (cs_n |-> !sclk)
      else $error("clock high while deselected");
   chk_sclk_high: assert property ($rose(sclk) |=> sclk [*8])
      else $error("clock high phase short");
   chk_sclk_low: assert property ($fell(sclk) |=> !sclk [*8])
      else $error("clock low phase short");
   chk_frame_lead: assert property (
      $fell(cs_n) |-> !sclk [*4])
      else $error("clock rises right after select");
   cover property ($fell(cs_n));
   cover property ($fell(d_oe_n[1]));
   cover property ($fell(d_oe_n[3]));
endmodule : sfr_chk

// >>> serial_flash_read_path_test.sv
/*
 bench: host and flash ends joined by the link, a memory that answers
 each request with a byte made from its address. assumes the package.
*/
`timescale 1ns/1ps
module serial_flash_read_path_test;
   import sfr_pkg::*;
   logic        clk = 0, srst = 1, start = 0, dtr_en = 0, addr4 = 0;
   logic        ce = 1, nv_a4 = 0;
   logic        a4_on = 0, a4_off = 0, mem_valid = 0, mem_ready, d_busy;
   logic        req_valid, rx_valid, done, h_busy;
   logic [7:0]  opcode = 0, mem_data = 0, rx_data;
   logic [31:0] addr = 0, r;
   logic [15:0] nbytes = 3;
   logic [24:0] req_addr, a_r;
   logic [4:0]  dummy_cfg = 0;
   sfr_proto_t  proto = SFR_EXT;
   int          err_count = 0, num_checks = 0, seed = 39;
   logic [7:0]  exp_q[$];
   localparam logic [7:0] OPS [21] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h6b,
      8'heb, 8'h0d, 8'h3d, 8'hbd, 8'h6d, 8'hed, 8'he7, 8'h13, 8'h0c, 8'h3c,
      8'hbc, 8'h6c, 8'hec, 8'h0e, 8'hbe, 8'hee};
   sfr_link_if lnk ();
   sfr_dev #(.ADDR_W(25), .FIFO_D(8)) sfr_dev_i (.clk(clk), .srst(srst),
      .ce(ce), .lnk(lnk), .proto(proto), .dtr_en(dtr_en),
      .nv_addr4(nv_a4), .addr4_enter(a4_on), .addr4_exit(a4_off),
      .dummy_cfg(dummy_cfg), .req_valid(req_valid), .req_addr(req_addr),
      .mem_valid(mem_valid), .mem_data(mem_data), .mem_ready(mem_ready),
      .busy(d_busy));
   sfr_host #(.HALF(12)) sfr_host_i (.clk(clk), .srst(srst), .ce(ce),
      .lnk(lnk), .start(start), .opcode(opcode), .addr(addr),
      .nbytes(nbytes), .proto(proto), .dtr_en(dtr_en), .addr4(addr4),
      .dummy_cfg(dummy_cfg), .busy(h_busy), .rx_valid(rx_valid),
      .rx_data(rx_data), .done(done));
   sfr_chk sfr_chk_i (.clk(clk), .srst(srst), .cs_n(lnk.cs_n),
      .sclk(lnk.sclk), .h_oe_n(lnk.h_oe_n), .d_oe_n(lnk.d_oe_n));
   initial forever #20 clk = ~clk;
   function automatic logic [7:0] pat(input logic [24:0] a);
      return a[7:0] ^ a[15:8];
   endfunction : pat
   // the memory shares the enable, so a pause stretches every clock alike
   always @(posedge clk) begin
      if (ce) begin
         mem_valid <= req_valid;
         mem_data <= pat(req_addr);
      end
   end
   task automatic check(input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t exp %h got %h", $time, e, g);
      end
   endtask : check
   always @(posedge clk) begin
      if (rx_valid === 1'b1) begin
         if (exp_q.size() == 0) check(32'h100, {24'h0, rx_data});
         else check({24'h0, exp_q.pop_front()}, {24'h0, rx_data});
      end
   end
   // mute: the flash is expected to ignore the read and send nothing
   task automatic run(input logic [7:0] op, input logic [24:0] a,
         input logic wide, input logic mute);
      for (int k = 0; k < 3; k++) begin
         if (!mute) exp_q.push_back(pat(a + 25'(k)));
      end
      @(posedge clk);
      #1 start = 1;
      opcode = op;
      addr = {7'h00, a};
      addr4 = wide;
      @(posedge clk);
      #1 start = 0;
      do begin
         @(posedge clk);
         #1;
      end while (done !== 1'b1);
      check(32'(exp_q.size()), 32'h0);
      repeat (8) @(posedge clk);
      #1;
   endtask : run
   task finish_test;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test
   initial begin
      #3_500_000;
      err_count++;
      finish_test;
   end
   initial begin
      repeat (8) @(posedge clk);
      #1 srst = 0;
      for (int i = 0; i < 21; i++) begin
         r = $random(seed) & 32'hfffffffe;
         dummy_cfg = r[30:26] & 5'h0c;
         a_r = (i >= 12) ? r[24:0] : {1'b0, r[23:0]};
         run(OPS[i], a_r, i >= 12, 0);
      end
      a4_on = 1;
      @(posedge clk);
      #1 a4_on = 0;
      run(8'h03, 25'h1fffffe, 1, 0);
      a4_off = 1;
      @(posedge clk);
      #1 a4_off = 0;
      dtr_en = 1;
      fork
         run(8'h0b, 25'h0abcde, 0, 0);
         begin
            // a pause mid-frame must stretch the transfer, not corrupt it
            repeat (600) @(posedge clk);
            #1 ce = 0;
            repeat (5) @(posedge clk);
            #1 ce = 1;
         end
      join
      dtr_en = 0;
      proto = SFR_QUAD;
      run(8'he7, 25'h0ffffe, 0, 0);
      run(8'heb, 25'h000100, 0, 0);
      proto = SFR_DUAL;
      run(8'hbb, 25'h123456, 0, 0);
      run(8'he7, 25'h000010, 0, 1);
      // second reset with the width strap set: reads take four bytes
      nv_a4 = 1;
      srst = 1;
      repeat (3) @(posedge clk);
      #1 srst = 0;
      run(8'h0b, 25'h0000fe, 1, 0);
      finish_test;
   end
endmodule : serial_flash_read_path_test
